// *** addr_gen_if.sv ***
// Carrier between the sequencer and its address generator
// Assumes both ends run combinationally inside one clock domain
`timescale 1ns/100ps
interface addr_gen_if;
   import sync_burst_pkg::*;
   word_addr_t launchAddr;
   word_addr_t startAddr;
   logic [2:0] sizeCode;
   logic noWrap;
   logic holdTwo;
   logic [2:0] latency;
   word_addr_t nextAddr;
   logic [4:0] burstLen;
   logic isCont;
   logic [2:0] rowStall;

   modport seq (output launchAddr, startAddr, sizeCode, noWrap, holdTwo,
      latency, input nextAddr, burstLen, isCont, rowStall);
   modport gen (input launchAddr, startAddr, sizeCode, noWrap, holdTwo,
      latency, output nextAddr, burstLen, isCont, rowStall);
endinterface

// *** burst_addr_gen.sv ***
// Address order and row-crossing stall computation
// Assumes the sequencer drives its inputs from registers on mclk
`timescale 1ns/100ps
module burst_addr_gen
   import sync_burst_pkg::*;
(
   // Sequencer side
   addr_gen_if.gen ag
);

   // ====================================================================
   // Length decode
   function automatic logic [4:0] lenOf(input logic [2:0] code);
      case (code)
         `BL_4: lenOf = 5'h04;
         `BL_8: lenOf = 5'h08;
         `BL_16: lenOf = 5'h10;
         default: lenOf = 5'h00;
      endcase
   endfunction

   wire [4:0] len = lenOf(ag.sizeCode);
   wire cont = (ag.sizeCode == `BL_CONT);
   wire [3:0] wrapMask = 4'(len - 5'h01);
   wire [3:0] lowInc = 4'(ag.launchAddr[3:0] + 4'h1);
   wire linear = cont || ag.noWrap;
   wire [3:0] wrapLow = (lowInc & wrapMask) |
      (ag.launchAddr[3:0] & ~wrapMask);

   // ====================================================================
   // Row crossing
   wire [4:0] toRow = `ROW_WORDS - {1'b0, ag.startAddr[3:0]};
   wire [5:0] endPos = {2'b00, ag.startAddr[3:0]} + {1'b0, len};
   wire crosses = cont || (endPos > 6'(`ROW_WORDS));
   wire aligned = (ag.startAddr[1:0] == 2'b00);
   wire stallOn = ag.noWrap && !ag.holdTwo && crosses && !aligned;
   wire [4:0] lat5 = {2'b00, ag.latency};

   // ====================================================================
   // Outputs
   assign ag.nextAddr = linear ? word_addr_t'(ag.launchAddr + 1'b1) :
      {ag.launchAddr[`ADDR_W-1:4], wrapLow};
   assign ag.burstLen = len;
   assign ag.isCont = cont;
   assign ag.rowStall = (stallOn && lat5 > toRow) ?
      3'(lat5 - toRow) : 3'h0;

endmodule // burst_addr_gen

// *** host_bus_model.sv ***
// Host controller model: frames bursts and collects words per edge
// Assumes wait polarity is active high
`timescale 1ns/100ps
`include "sync_burst_regs.svh"
module host_bus_model
   import sync_burst_pkg::*;
(
   // Clock and edge choice
   input wire logic mclk,
   input wire logic risingSel,
   // Pins towards the device
   output logic flashClk,
   output logic addressValidN,
   output logic chipEnableN,
   output logic outputEnableN,
   output logic [`ADDR_W-1:0] addrPin,
   // Pins from the device
   input wire logic [`DATA_W-1:0] dqOut,
   input wire logic dqOe,
   input wire logic waitOut,
   input wire logic waitOe
);
   word_data_t words[$];
   int edges[$];
   int edgeCnt;
   int waitFall;
   logic prevOe;
   logic prevWait;
   word_data_t prevDq;
   initial begin
      flashClk = 1'b0;
      addressValidN = 1'b1;
      chipEnableN = 1'b1;
      outputEnableN = 1'b1;
      addrPin = '0;
      edgeCnt = -1;
      waitFall = -1;
   end
   // ===========================================================
   // Capture: data only while wait is deasserted
   always @(posedge mclk) begin
      if (dqOe && !waitOut && (!prevOe || dqOut !== prevDq)) begin
         words.push_back(dqOut);
         edges.push_back(edgeCnt);
      end
      if (waitOe && prevWait && !waitOut && waitFall < 0) begin
         waitFall = edgeCnt;
      end
      prevOe <= dqOe;
      prevWait <= waitOut;
      prevDq <= dqOut;
   end
   // ===========================================================
   // One framed burst; clock stands still outside it
   task automatic run(input word_addr_t start, input int nEdges);
      words.delete();
      edges.delete();
      edgeCnt = -1;
      waitFall = -1;
      @(posedge mclk);
      chipEnableN <= 1'b0;
      outputEnableN <= 1'b0;
      addressValidN <= 1'b0;
      addrPin <= start;
      repeat (4) @(posedge mclk);
      for (int t = 0; t < 2 * nEdges; t++) begin
         @(posedge mclk);
         flashClk <= ~flashClk;
         if (flashClk != risingSel) edgeCnt <= edgeCnt + 1;
         if (edgeCnt >= 0 && !addressValidN) begin
            addressValidN <= 1'b1;
            addrPin <= ~addrPin;
         end
         repeat (4) @(posedge mclk);
      end
      repeat (8) @(posedge mclk);
      chipEnableN <= 1'b1;
      outputEnableN <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask
endmodule // host_bus_model

// *** sync_burst_checker.sv ***
// Port-level assertions for the burst-read sequencer
// Assumes config is written only while no burst is running
`timescale 1ns/100ps
`include "sync_burst_regs.svh"
module sync_burst_checker
   import sync_burst_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdData,
   // Host pins
   input wire logic flashClk,
   input wire logic addressValidN,
   input wire logic chipEnableN,
   input wire logic outputEnableN,
   input wire logic [`ADDR_W-1:0] addrPin,
   // Array and data pins
   input wire logic [`ADDR_W-1:0] arrayAddr,
   input wire logic [`DATA_W-1:0] arrayData,
   input wire logic [`DATA_W-1:0] dqOut,
   input wire logic dqOe,
   input wire logic waitOut,
   input wire logic waitOe
);
   // ===========================================================
   // Config shadow
   logic [15:0] cfg;
   logic waitAct;
   assign waitAct = (waitOut == cfg[`WP_BIT]);
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= `CFG_RESET;
      end else if (regWr && regAddr == `CFG_OFS) begin
         cfg <= regWrData & `CFG_MASK;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // ===========================================================
   // Assertions
   a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 16'h0)
      else $error("read data not zero outside read slot");
   a_cfg_read_back: assert property (
      $past(regRd && regAddr == `CFG_OFS) |-> regRdData == $past(cfg))
      else $error("config read back wrong");
   a_order_refused: assert property (!cfg[`BS_BIT] |-> !dqOe)
      else $error("data driven with unsupported order");
   a_size_refused: assert property (
      !(cfg[2:0] inside {`BL_4, `BL_8, `BL_16, `BL_CONT}) |-> !dqOe)
      else $error("data driven with unsupported size");
   a_data_wait_off: assert property (dqOe |-> !waitAct)
      else $error("wait asserted during valid data");
   a_data_needs_bus: assert property (dqOe |-> waitOe)
      else $error("data driven without bus enables");
   a_stall_wait_on: assert property (
      $fell(dqOe) && waitOe |-> waitAct)
      else $error("data gap without wait");
   a_bus_off: assert property (chipEnableN [*4] |-> !waitOe && !dqOe)
      else $error("pins driven while deselected");
endmodule // sync_burst_checker

bind sync_burst_read_sequencer sync_burst_checker chk (.mclk(mclk),
   .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .flashClk(flashClk), .addressValidN(addressValidN),
   .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
   .addrPin(addrPin), .arrayAddr(arrayAddr), .arrayData(arrayData),
   .dqOut(dqOut), .dqOe(dqOe), .waitOut(waitOut), .waitOe(waitOe));

// *** sync_burst_pkg.sv ***
// Types shared by the burst-read sequencer modules
// Assumes the register header sits in the include path
package sync_burst_pkg;
`include "sync_burst_regs.svh"

   typedef logic [`ADDR_W-1:0] word_addr_t;
   typedef logic [`DATA_W-1:0] word_data_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_LAT = 3'b001,
      ST_DATA = 3'b010,
      ST_ROW = 3'b011,
      ST_DONE = 3'b100
   } burst_state_e;

endpackage

// *** sync_burst_read_sequencer.sv ***
// Synchronous burst-read sequencer: address order, edge choice, wait
// Assumes array data answer combinationally to arrayAddr on mclk and
// that all pins come from the host's clock domain, sampled twice
//
// Summary of operation
// - Wait lead bit set: wait ends one data cycle early, else with data.
// - Only linear order; the other order encoding refuses bursts.
// - Size field picks 4, 8, 16 words or continuous bursts.
// - Wrap bit clear wraps, set does not; set is the default.
// - Wrap mode counts modulo length inside the aligned group.
// - No-wrap counts linearly from start across group boundaries.
// - Continuous bursts always count linearly, never wrap.
// - Continuous bursts run until the top of the address space.
// - Edge select bit picks rising or falling clock for everything.
// - No-wrap with one-clock hold may stall once at first row crossing.
// - Start aligned to four words never stalls at the row crossing.
// - Last word of a group start stalls at most latency minus one.
// - Other starts stall by latency and position within the row.
// - Wait stays asserted through row crossing stall cycles, except the last one with the wait lead bit set.
// - Latency counts edges from address strobe to first data word.
// - Wait lead bit sits at bit 8, reset value one.
// - Wait is deasserted while bus data are valid, and one data cycle before them with the wait lead bit set.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module sync_burst_read_sequencer
   import sync_burst_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   // Host pins
   input wire logic flashClk,
   input wire logic addressValidN,
   input wire logic chipEnableN,
   input wire logic outputEnableN,
   input wire logic [`ADDR_W-1:0] addrPin,
   // Array side
   output logic [`ADDR_W-1:0] arrayAddr,
   input wire logic [`DATA_W-1:0] arrayData,
   // Data and wait pins
   output logic [`DATA_W-1:0] dqOut,
   output logic dqOe,
   output logic waitOut,
   output logic waitOe
);

   // ====================================================================
   // Configuration register
   logic [15:0] read_config_reg;
   wire cfgSel = (regAddr == `CFG_OFS);
   wire statSel = (regAddr == `STAT_OFS);
   wire syncMode = !read_config_reg[`RM_BIT];
   wire [2:0] first_access_latency = read_config_reg[`LC_HI:`LC_LO];
   wire waitHigh = read_config_reg[`WP_BIT];
   wire data_hold_select = read_config_reg[`DH_BIT];
   wire wait_lead_select = read_config_reg[`WD_BIT];
   wire burst_order_select = read_config_reg[`BS_BIT];
   wire risingSel = read_config_reg[`CE_BIT];
   wire no_wrap_select = read_config_reg[`BW_BIT];
   wire [2:0] burst_size_field = read_config_reg[`BL_HI:`BL_LO];

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         read_config_reg <= `CFG_RESET;
      end else if (regWr && cfgSel) begin
         read_config_reg <= regWrData & `CFG_MASK;
      end
   end

   // ====================================================================
   // Pin synchronisers
   logic clkA, clkB, clkPrev;
   logic advA, advB, ceA, ceB, oeA, oeB;
   logic [`ADDR_W-1:0] addrA, addrB;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         clkA <= 1'b0;
         clkB <= 1'b0;
         clkPrev <= 1'b0;
         advA <= 1'b1;
         advB <= 1'b1;
         ceA <= 1'b1;
         ceB <= 1'b1;
         oeA <= 1'b1;
         oeB <= 1'b1;
         addrA <= '0;
         addrB <= '0;
      end else begin
         clkA <= flashClk;
         clkB <= clkA;
         clkPrev <= clkB;
         advA <= addressValidN;
         advB <= advA;
         ceA <= chipEnableN;
         ceB <= ceA;
         oeA <= outputEnableN;
         oeB <= oeA;
         addrA <= addrPin;
         addrB <= addrA;
      end
   end

   // ====================================================================
   // Edge choice and configuration checks
   wire riseEdge = clkB && !clkPrev;
   wire fallEdge = !clkB && clkPrev;
   wire activeEdge = risingSel ? riseEdge : fallEdge;
   wire sizeOk = (burst_size_field == `BL_4) ||
      (burst_size_field == `BL_8) ||
      (burst_size_field == `BL_16) ||
      (burst_size_field == `BL_CONT);
   wire orderOk = burst_order_select;
   wire cfgUnsupported = !sizeOk || !orderOk;
   wire burstStart = activeEdge && !ceB && !advB && syncMode &&
      !cfgUnsupported;
   wire [1:0] holdLen = data_hold_select ? 2'h2 : 2'h1;

   // ====================================================================
   // Address generator
   addr_gen_if ag ();
   word_addr_t launchAddr, startAddr;

   assign ag.launchAddr = launchAddr;
   assign ag.startAddr = startAddr;
   assign ag.sizeCode = burst_size_field;
   assign ag.noWrap = no_wrap_select;
   assign ag.holdTwo = data_hold_select;
   assign ag.latency = first_access_latency;

   burst_addr_gen addrGen (
      .ag(ag.gen)
   );

   // ====================================================================
   // Burst state
   burst_state_e state;
   logic [2:0] edgeCnt;
   logic [1:0] holdCnt;
   logic [4:0] wordsLeft;
   logic finalWord;
   logic rowDone;
   logic waitAct;
   logic dataValid;

   wire topWord = (launchAddr == {`ADDR_W{1'b1}});
   wire lastLaunch = ag.isCont ? topWord : (wordsLeft == 5'h01);
   wire rowEntry = (launchAddr[3:0] == 4'h0) && !rowDone &&
      (ag.rowStall != 3'h0);
   wire [2:0] edgeDec = 3'(edgeCnt - 3'h1);
   wire latEarly = wait_lead_select && ({1'b0, edgeDec} <= {2'b00, holdLen});
   wire rowEarly = wait_lead_select && (edgeDec <= 3'h1);
   wire startEarly = wait_lead_select &&
      (first_access_latency <= {1'b0, holdLen});
   wire stallEarly = wait_lead_select && (ag.rowStall <= 3'h1);

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         edgeCnt <= 3'h0;
         holdCnt <= 2'h0;
         wordsLeft <= 5'h00;
         finalWord <= 1'b0;
         rowDone <= 1'b0;
         waitAct <= 1'b0;
         dataValid <= 1'b0;
         launchAddr <= '0;
         startAddr <= '0;
         dqOut <= '0;
      end else if (ceB) begin
         state <= ST_IDLE;
         waitAct <= 1'b0;
         dataValid <= 1'b0;
      end else if (burstStart) begin
         state <= ST_LAT;
         edgeCnt <= first_access_latency;
         launchAddr <= addrB;
         startAddr <= addrB;
         wordsLeft <= ag.burstLen;
         rowDone <= 1'b0;
         finalWord <= 1'b0;
         dataValid <= 1'b0;
         waitAct <= !startEarly;
      end else if (activeEdge) begin
         case (state)
            ST_LAT, ST_ROW: begin
               if (edgeCnt <= 3'h1) begin
                  state <= ST_DATA;
                  dqOut <= arrayData;
                  launchAddr <= ag.nextAddr;
                  holdCnt <= 2'(holdLen - 2'h1);
                  wordsLeft <= 5'(wordsLeft - 5'h01);
                  finalWord <= lastLaunch;
                  dataValid <= 1'b1;
                  waitAct <= 1'b0;
               end else begin
                  edgeCnt <= edgeDec;
                  waitAct <= (state == ST_LAT) ? !latEarly :
                     !rowEarly;
               end
            end
            ST_DATA: begin
               if (holdCnt != 2'h0) begin
                  holdCnt <= 2'(holdCnt - 2'h1);
               end else if (finalWord) begin
                  state <= ST_DONE;
                  dataValid <= 1'b0;
                  waitAct <= 1'b1;
               end else if (rowEntry) begin
                  state <= ST_ROW;
                  edgeCnt <= ag.rowStall;
                  rowDone <= 1'b1;
                  dataValid <= 1'b0;
                  waitAct <= !stallEarly;
               end else begin
                  dqOut <= arrayData;
                  launchAddr <= ag.nextAddr;
                  holdCnt <= 2'(holdLen - 2'h1);
                  wordsLeft <= 5'(wordsLeft - 5'h01);
                  finalWord <= lastLaunch;
                  dataValid <= 1'b1;
                  waitAct <= 1'b0;
               end
            end
            ST_DONE: begin
               dataValid <= 1'b0;
            end
            default: begin
               state <= ST_IDLE;
               waitAct <= 1'b0;
               dataValid <= 1'b0;
            end
         endcase
      end
   end

   assign arrayAddr = launchAddr;

   // ====================================================================
   // Pin outputs
   wire busActive = !ceB && !oeB;
   wire waitLevel = waitHigh ? waitAct : !waitAct;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         waitOut <= 1'b0;
         waitOe <= 1'b0;
         dqOe <= 1'b0;
      end else begin
         waitOut <= waitLevel;
         waitOe <= busActive;
         dqOe <= busActive && dataValid;
      end
   end

   // ====================================================================
   // Register read port
   wire [15:0] statusWord = {8'h00, rowDone, cfgUnsupported, dataValid,
      waitAct, finalWord, state};
   wire [15:0] readMux = cfgSel ? read_config_reg :
      statSel ? statusWord : 16'h0000;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= 16'h0000;
      end else if (regRd) begin
         regRdData <= readMux;
      end else begin
         regRdData <= 16'h0000;
      end
   end

endmodule // sync_burst_read_sequencer

// *** sync_burst_regs.svh ***
// Offsets, field positions and reset values of the burst-read sequencer
// Assumes inclusion by bare name from the package and design modules
`ifndef SYNC_BURST_REGS_SVH
`define SYNC_BURST_REGS_SVH

// ====================================================================
// Register offsets
`define CFG_OFS 4'h0
`define STAT_OFS 4'h4

// ====================================================================
// Configuration fields
`define CFG_RESET 16'hBFCF
`define CFG_MASK 16'hBFCF
`define RM_BIT 15
`define LC_HI 13
`define LC_LO 11
`define WP_BIT 10
`define DH_BIT 9
`define WD_BIT 8
`define BS_BIT 7
`define CE_BIT 6
`define BW_BIT 3
`define BL_HI 2
`define BL_LO 0

// ====================================================================
// Burst length codes and sizes
`define BL_4 3'h1
`define BL_8 3'h2
`define BL_16 3'h3
`define BL_CONT 3'h7
`define ROW_WORDS 5'h10
`define ADDR_W 16
`define DATA_W 16

`endif

// *** tb_top.sv ***
// Self-checking bench for the burst-read sequencer
// Assumes array data equal the word address with a fixed mask
`timescale 1ns/100ps
`include "sync_burst_regs.svh"
module tb_top
   import sync_burst_pkg::*;
;
   logic mclk, sys_rst, regWr, regRd, risingSel;
   logic [3:0] regAddr;
   logic [15:0] regWrData, regRdData, rd;
   logic flashClk, addressValidN, chipEnableN, outputEnableN;
   word_addr_t addrPin, arrayAddr;
   word_data_t arrayData, dqOut;
   logic dqOe, waitOut, waitOe;
   int n_errors, total_checks;
   assign arrayData = arrayAddr ^ 16'h5A00;
   sync_burst_read_sequencer uut (.mclk(mclk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .flashClk(flashClk),
      .addressValidN(addressValidN), .chipEnableN(chipEnableN),
      .outputEnableN(outputEnableN), .addrPin(addrPin),
      .arrayAddr(arrayAddr), .arrayData(arrayData), .dqOut(dqOut),
      .dqOe(dqOe), .waitOut(waitOut), .waitOe(waitOe));
   host_bus_model host (.mclk(mclk), .risingSel(risingSel),
      .flashClk(flashClk), .addressValidN(addressValidN),
      .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
      .addrPin(addrPin), .dqOut(dqOut), .dqOe(dqOe), .waitOut(waitOut),
      .waitOe(waitOe));
   always #2 mclk = ~mclk;
   // ===========================================================
   // Compare, bus and burst tasks
   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_num(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   function automatic logic [15:0] mk(input logic [2:0] lc, input logic dh,
      input logic wd, input logic ce, input logic bw, input logic [2:0] bl);
      return {2'b00, lc, 1'b1, dh, wd, 1'b1, ce, 2'b00, bw, bl};
   endfunction
   task automatic burst(input logic [15:0] cfg, input word_addr_t start,
      input int n);
      int lc, hold, off, stall;
      word_addr_t a, len;
      lc = int'(cfg[13:11]);
      hold = int'(cfg[9]) + 1;
      off = 16 - int'(start[3:0]);
      len = 16'h2 << cfg[2:0];
      stall = (cfg[3] && !cfg[9] && start[1:0] != 2'h0 && lc > off &&
         (cfg[2:0] == `BL_CONT || int'(start[3:0]) + n > 16)) ? lc - off : 0;
      reg_write(`CFG_OFS, cfg);
      risingSel = cfg[6];
      host.run(start, lc + n * hold + stall + 4);
      if (cfg[2:0] != `BL_CONT || int'(start) + n == 65536)
         check_num(host.words.size(), n);
      else
         check_num(int'(host.words.size() >= n), 1);
      for (int i = 0; i < n && i < host.words.size(); i++) begin
         if (cfg[2:0] == `BL_CONT || cfg[3]) a = start + i;
         else a = (start & ~(len - 1)) | ((start + i) & (len - 1));
         check16(host.words[i], a ^ 16'h5A00);
         check_num(host.edges[i], lc + i * hold + ((i >= off) ? stall : 0));
      end
      if (!cfg[9] && n > 0) check_num(host.waitFall, lc - int'(cfg[8]));
      if (n == 0) check_num(host.waitFall, -1);
   endtask
   task automatic complete_run();
      $display("Checks: %0d  mismatches: %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ===========================================================
   // Main sequence and watchdog
   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWrData = 16'h0;
      risingSel = 1'b1;
      n_errors = 0;
      total_checks = 0;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      reg_read(`CFG_OFS, rd);
      check16(rd, 16'hBFCF);
      reg_read(4'h8, rd);
      check16(rd, 16'h0000);
      reg_write(`CFG_OFS, 16'hFFFF);
      reg_read(`CFG_OFS, rd);
      check16(rd, 16'hBFCF);
      burst(mk(3'h3, 1'b0, 1'b1, 1'b1, 1'b0, `BL_4), 16'h0122, 4);
      burst(mk(3'h4, 1'b0, 1'b0, 1'b1, 1'b0, `BL_8), 16'h0035, 8);
      burst(mk(3'h7, 1'b0, 1'b1, 1'b1, 1'b0, `BL_16), 16'h004F, 16);
      burst(mk(3'h7, 1'b0, 1'b1, 1'b1, 1'b1, `BL_CONT), 16'h4F, 20);
      burst(mk(3'h3, 1'b1, 1'b1, 1'b1, 1'b1, `BL_4), 16'h0003, 4);
      burst(mk(3'h2, 1'b0, 1'b0, 1'b1, 1'b0, `BL_CONT), 16'h0006, 12);
      burst(mk(3'h3, 1'b0, 1'b1, 1'b1, 1'b1, `BL_CONT), 16'hFFFC, 4);
      burst(mk(3'h7, 1'b0, 1'b1, 1'b1, 1'b1, `BL_16), 16'h000C, 16);
      burst(mk(3'h7, 1'b0, 1'b1, 1'b1, 1'b1, `BL_16), 16'h000F, 16);
      burst(mk(3'h7, 1'b0, 1'b0, 1'b1, 1'b1, `BL_16), 16'h000E, 16);
      burst(mk(3'h3, 1'b0, 1'b1, 1'b1, 1'b1, `BL_8), 16'h00FD, 8);
      burst(mk(3'h3, 1'b0, 1'b0, 1'b1, 1'b1, `BL_8), 16'h00FE, 8);
      burst(mk(3'h4, 1'b0, 1'b1, 1'b0, 1'b1, `BL_8), 16'h0200, 8);
      burst(mk(3'h3, 1'b0, 1'b1, 1'b1, 1'b1, `BL_4) & 16'hFF7F, 16'h10, 0);
      burst(mk(3'h3, 1'b0, 1'b1, 1'b1, 1'b1, 3'h4), 16'h0010, 0);
      complete_run();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      n_errors++;
      complete_run();
   end
endmodule // tb_top
